/* tuning_cfg_pkg.sv */
// constants and carrier types for the signal chain and tuning load bank
package tuning_cfg_pkg;
  localparam int         ADDR_W          = 12;
  localparam int         NUM_BYTES       = 6;
  localparam int         WORD_W          = 48;
  // register addresses
  localparam logic [11:0] ADDR_CHAIN     = 12'h111;
  localparam logic [11:0] ADDR_LOAD_CTL  = 12'h113;
  localparam logic [11:0] ADDR_WORD_BASE = 12'h114;
  // signal chain setup bit positions
  localparam int         BIT_INV_SINC    = 7;
  localparam int         BIT_MIX_ON      = 6;
  localparam int         BIT_PASSBAND    = 4;
  localparam int         BIT_FRAC_MOD    = 2;
  localparam int         BIT_SIDEBAND    = 1;
  localparam int         BIT_DOUBLE_RATE = 0;
  localparam logic [7:0] CHAIN_WR_MASK   = 8'hd7;
  // load control bit positions
  localparam int         TRIG_LSB        = 4;
  localparam int         TRIG_MSB        = 6;
  localparam int         BIT_SYNC_EDGE   = 2;
  localparam int         BIT_LOAD_DONE   = 1;
  localparam int         BIT_LOAD_REQ    = 0;
  localparam logic [2:0] TRIG_NONE       = 3'h0;
  localparam logic [2:0] TRIG_LAST       = 3'h6;
  localparam logic [7:0] RESET_BYTE      = 8'h00;

  typedef logic [7:0] byte_t;

  // register port request from the serial control core
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    byte_t             wdata;
  } reg_req_t;

  // steering of the signal chain
  typedef struct packed {
    logic inverse_sinc_on;
    logic oscillator_mix_on;
    logic passband_select;
    logic frac_modulus_on;
    logic lower_sideband;
    logic double_rate_filter_on;
  } chain_ctl_t;

  // complete block state
  typedef struct packed {
    byte_t                      chain;
    logic [2:0]                 auto_load_trigger_select;
    logic                       sync_edge_load;
    logic                       tuning_load_request;
    logic                       tuning_load_done;
    logic [NUM_BYTES-1:0][7:0]  tuning_word;
    logic [WORD_W-1:0]          active_word;
    logic [WORD_W-1:0]          active_modulus;
    logic                       sync_prev;
    logic                       auto_pending;
    logic                       osc_reset;
    logic                       load_strobe;
    byte_t                      rdata;
  } state_t;
endpackage : tuning_cfg_pkg

/* datapath_config_tuning_load.sv */
// signal chain setup and oscillator tuning word load registers
`timescale 1ns/10ps
module datapath_config_tuning_load
  import tuning_cfg_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire reg_req_t          reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic              sysref_in,
  input  wire logic [WORD_W-1:0] shared_modulus,
  output chain_ctl_t             chain_ctl,
  output logic [WORD_W-1:0]      active_word,
  output logic [WORD_W-1:0]      active_modulus,
  output logic                   load_strobe,
  output logic                   osc_reset
);

  state_t state_r;
  state_t state_nxt;

  // index of a tuning byte address, or NUM_BYTES when not one
  function automatic logic [2:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_WORD_BASE;
    if (a >= ADDR_WORD_BASE && d < ADDR_W'(NUM_BYTES)) begin
      return d[2:0];
    end
    return 3'(NUM_BYTES);
  endfunction : word_index

  // next state: register writes, triggers and the tuning transfer
  always_comb begin
    logic       wr_chain;
    logic       wr_ctl;
    logic [2:0] idx;
    logic       sw_rise;
    logic       sync_rise;
    logic       do_load;
    state_nxt             = state_r;
    state_nxt.osc_reset   = 1'b0;
    state_nxt.load_strobe = 1'b0;
    wr_chain  = reg_req.wr && reg_req.addr == ADDR_CHAIN;
    wr_ctl    = reg_req.wr && reg_req.addr == ADDR_LOAD_CTL;
    idx       = word_index(reg_req.addr);
    // only a rising write counts, a held 1 rewritten loads nothing
    sw_rise   = wr_ctl && reg_req.wdata[BIT_LOAD_REQ]
                && !state_r.tuning_load_request;
    sync_rise = sysref_in && !state_r.sync_prev;
    state_nxt.sync_prev = sysref_in;

    // reserved bits 5 and 3 stay zero
    if (wr_chain) begin
      state_nxt.chain = reg_req.wdata & CHAIN_WR_MASK;
    end
    if (wr_ctl) begin
      state_nxt.auto_load_trigger_select =
        reg_req.wdata[TRIG_MSB:TRIG_LSB];
      state_nxt.sync_edge_load      = reg_req.wdata[BIT_SYNC_EDGE];
      state_nxt.tuning_load_request = reg_req.wdata[BIT_LOAD_REQ];
      if (!reg_req.wdata[BIT_LOAD_REQ]) begin
        state_nxt.tuning_load_done = 1'b0;
      end
    end

    // byte writes; a matching trigger code loads two cycles after the write
    state_nxt.auto_pending = 1'b0;
    if (reg_req.wr && idx != 3'(NUM_BYTES)) begin
      state_nxt.tuning_word[idx] = reg_req.wdata;
      if (state_r.auto_load_trigger_select != TRIG_NONE &&
          state_r.auto_load_trigger_select <= TRIG_LAST &&
          state_r.auto_load_trigger_select == idx + 3'h1) begin
        state_nxt.auto_pending = 1'b1;
      end
    end

    // transfer uses the bytes as stored before this cycle's write
    do_load = sw_rise || state_r.auto_pending
              || (state_r.sync_edge_load && sync_rise);
    if (do_load) begin
      state_nxt.active_word    = state_r.tuning_word;
      state_nxt.active_modulus = shared_modulus;
      state_nxt.load_strobe    = 1'b1;
      state_nxt.tuning_load_done = 1'b1;
    end
    if (state_r.sync_edge_load && sync_rise) begin
      state_nxt.osc_reset = 1'b1;
    end

    // registered read data, unmapped addresses read zero
    state_nxt.rdata = RESET_BYTE;
    if (reg_req.rd) begin
      if (reg_req.addr == ADDR_CHAIN) begin
        state_nxt.rdata = state_r.chain;
      end else if (reg_req.addr == ADDR_LOAD_CTL) begin
        state_nxt.rdata[TRIG_MSB:TRIG_LSB] =
          state_r.auto_load_trigger_select;
        state_nxt.rdata[BIT_SYNC_EDGE] = state_r.sync_edge_load;
        state_nxt.rdata[BIT_LOAD_DONE] = state_r.tuning_load_done;
        state_nxt.rdata[BIT_LOAD_REQ]  = state_r.tuning_load_request;
      end else if (idx != 3'(NUM_BYTES)) begin
        state_nxt.rdata = state_r.tuning_word[idx];
      end
    end
  end

  // single state register, synchronous reset to all zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // chain steering straight from the setup register
  assign chain_ctl.inverse_sinc_on       = state_r.chain[BIT_INV_SINC];
  assign chain_ctl.oscillator_mix_on     = state_r.chain[BIT_MIX_ON];
  assign chain_ctl.passband_select       = state_r.chain[BIT_PASSBAND];
  assign chain_ctl.frac_modulus_on       = state_r.chain[BIT_FRAC_MOD];
  assign chain_ctl.lower_sideband        = state_r.chain[BIT_SIDEBAND];
  assign chain_ctl.double_rate_filter_on = state_r.chain[BIT_DOUBLE_RATE];

  assign reg_rdata      = state_r.rdata;
  assign active_word    = state_r.active_word;
  assign active_modulus = state_r.active_modulus;
  assign load_strobe    = state_r.load_strobe;
  assign osc_reset      = state_r.osc_reset;

endmodule : datapath_config_tuning_load

/* tuning_load_chk.sv */
// port checker for the chain setup and tuning load bank
`timescale 1ns/10ps
module tuning_load_chk
  import tuning_cfg_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire reg_req_t          reg_req,
  input wire logic [7:0]        reg_rdata,
  input wire logic              sysref_in,
  input wire logic [WORD_W-1:0] shared_modulus,
  input wire chain_ctl_t        chain_ctl,
  input wire logic [WORD_W-1:0] active_word,
  input wire logic [WORD_W-1:0] active_modulus,
  input wire logic              load_strobe,
  input wire logic              osc_reset
);
  logic [2:0] trig_r;
  logic       req_r, sync_r, ctl_wr;
  assign ctl_wr = reg_req.wr && reg_req.addr == ADDR_LOAD_CTL;
  // shadow of the load control bits, rebuilt from the writes seen
  always_ff @(posedge core_clk)
    if (rst) {trig_r, sync_r, req_r} <= '0;
    else if (ctl_wr)
      {trig_r, sync_r, req_r} <= {reg_req.wdata[6:4], reg_req.wdata[2],
                                  reg_req.wdata[0]};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chain_wr_a: assert property (reg_req.wr && reg_req.addr == ADDR_CHAIN |=>
    chain_ctl == {$past(reg_req.wdata[7:6]), $past(reg_req.wdata[4]),
    $past(reg_req.wdata[2:0])}) else $error("chain setup not applied");
  chain_hold_a: assert property (!(reg_req.wr && reg_req.addr == ADDR_CHAIN)
    |=> $stable(chain_ctl)) else $error("chain setup moved");
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  word_hold_a: assert property (!load_strobe |-> $stable(active_word))
    else $error("word moved without load");
  mod_cap_a: assert property (load_strobe |->
    active_modulus == $past(shared_modulus)) else $error("modulus not taken");
  sw_load_a: assert property (ctl_wr && reg_req.wdata[0] && !req_r |=>
    load_strobe) else $error("request edge did not load");
  auto_load_a: assert property (reg_req.wr && trig_r inside {[1:6]} &&
    reg_req.addr == ADDR_WORD_BASE + {9'h0, trig_r} - 12'h1 |-> ##2
    load_strobe) else $error("auto load missing");
  sync_load_a: assert property (sync_r && $rose(sysref_in) |=>
    osc_reset && load_strobe) else $error("sync edge did not load");
  osc_cause_a: assert property (osc_reset |-> load_strobe &&
    $past(sysref_in) && !$past(sysref_in, 2)) else $error("stray osc reset");
  cover property (osc_reset);
  cover property (ctl_wr && reg_req.wdata[0] && req_r);
  cover property (load_strobe && !osc_reset);
endmodule : tuning_load_chk
bind datapath_config_tuning_load tuning_load_chk u_chk (.core_clk, .rst,
  .reg_req, .reg_rdata, .sysref_in, .shared_modulus, .chain_ctl,
  .active_word, .active_modulus, .load_strobe, .osc_reset);

/* tb_datapath_config_tuning_load.sv */
// self-checking bench for the chain setup and tuning load bank
`timescale 1ns/10ps
module tb_datapath_config_tuning_load;
  import tuning_cfg_pkg::*;
  `define CHK(n, a, b) begin samples_checked++; if ((a) !== (b)) begin \
    error_cnt++; $display("MISMATCH %s exp %h got %h", n, b, a); end end
  logic              core_clk, rst, sysref_in, rd_d, load_strobe, osc_reset;
  reg_req_t          reg_req;
  logic [7:0]        reg_rdata, d;
  logic [WORD_W-1:0] shared_modulus, active_word, active_modulus, word, e;
  chain_ctl_t        chain_ctl;
  logic [WORD_W-1:0] exp_q[$];
  int                error_cnt, samples_checked, cyc, osc_cnt;
  datapath_config_tuning_load dut (.core_clk, .rst, .reg_req, .reg_rdata,
    .sysref_in, .shared_modulus, .chain_ctl, .active_word, .active_modulus,
    .load_strobe, .osc_reset);
  initial begin core_clk = 0; forever #12.5 core_clk = ~core_clk; end
  task automatic req(logic w, logic r, logic [11:0] a, byte_t v);
    reg_req <= '{w, r, a, v};
    @(posedge core_clk);
  endtask : req
  task automatic idle(int n);
    reg_req <= '0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic rd_chk(logic [11:0] a, byte_t v);
    exp_q.push_back({40'h0, v});
    req(0, 1, a, 8'h00);
    idle(2);
  endtask : rd_chk
  task automatic wb(int k, byte_t v);
    word[8*k +: 8] = v;
    req(1, 0, ADDR_WORD_BASE + 12'(k), v);
  endtask : wb
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // results matched in arrival order; a hang is cut at a fixed ceiling
  always @(posedge core_clk) begin
    rd_d <= reg_req.rd;
    cyc <= cyc + 1;
    osc_cnt <= osc_cnt + int'(osc_reset); // every oscillator reset pulse
    if (cyc == 4000) begin error_cnt++; conclude(); end
    if (rd_d || load_strobe) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      `CHK("result", rd_d ? {40'h0, reg_rdata} : active_word, e)
    end
  end
  initial begin
    rst = 1; sysref_in = 0; reg_req = '0; word = '0;
    shared_modulus = '0;
    repeat (16) @(posedge core_clk);
    rst <= 0;
    void'($urandom(36));
    // zero after reset, unmapped places too
    for (int a = 'h111; a < 'h11b; a++) rd_chk(12'(a), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = i ? 8'($urandom) : 8'hff;
      req(1, 0, ADDR_CHAIN, d);
      idle(1);
      `CHK("chain", chain_ctl, {d[7:6], d[4], d[2:0]})
      rd_chk(ADDR_CHAIN, d & CHAIN_WR_MASK);
    end
    $display("test chain done");
    shared_modulus <= WORD_W'({$urandom, $urandom});
    for (int k = 0; k < NUM_BYTES; k++) wb(k, 8'($urandom));
    idle(2);
    exp_q.push_back(word);
    req(1, 0, ADDR_LOAD_CTL, 8'h01);
    idle(1);
    rd_chk(ADDR_LOAD_CTL, 8'h03);
    req(1, 0, ADDR_LOAD_CTL, 8'h01);
    req(1, 0, ADDR_LOAD_CTL, 8'h00);
    idle(1);
    rd_chk(ADDR_LOAD_CTL, 8'h00);
    $display("test request done");
    // a wrong byte first must not fire the trigger
    for (int k = 1; k <= NUM_BYTES; k++) begin
      req(1, 0, ADDR_LOAD_CTL, 8'(k << 4));
      wb(k % NUM_BYTES, 8'($urandom));
      wb(k - 1, 8'($urandom));
      exp_q.push_back(word);
      idle(3);
    end
    $display("test auto done");
    req(1, 0, ADDR_LOAD_CTL, 8'h04);
    shared_modulus <= WORD_W'({$urandom, $urandom});
    wb(3, 8'($urandom));
    idle(2);
    exp_q.push_back(word);
    sysref_in <= 1;
    repeat (4) @(posedge core_clk);
    sysref_in <= 0;
    `CHK("modulus", active_modulus, shared_modulus)
    idle(4);
    `CHK("pending", exp_q.size(), 0)
    `CHK("osc pulses", osc_cnt, 1)
    $display("test sync done");
    conclude();
  end
endmodule : tb_datapath_config_tuning_load
